/* File: verilog/flash_link_dev.sv */
// Device end of the two-wire debug link with flash programming registers.
// Assumes the link clock and data arrive asynchronously from the pins.
`timescale 1ns/1ns
`include "flash_link_defines.svh"

// Function
// R1: Address register routes data reads and writes
// R2: Control register at 0x02, RW, resets zero
// R3: Keys 0x02 then 0x01 enable programming
// R4: Enabled stays until system reset
// R5: Data register at 0xB4, RW, resets zero
// R6: Four flash command codes accepted
// R7: Link frames taken while device halted
// R8: Link pins shared with user functions
// R9: User input on data pin held while halted
module flash_link_dev (
    input wire logic i_clk, // System clock
    input wire logic i_rst, // Synchronous reset, high
    flash_link_if.dev lnk, // Link pins
    input wire logic i_halted, // Core and peripherals halted
    output logic o_prog_enabled, // Flash programming unlocked
    output logic o_cmd_valid, // Flash command pulse
    output logic [7:0] o_cmd_code, // Flash command code
    output logic o_data_wr, // Data register written pulse
    output logic [7:0] o_data_byte, // Data register value
    output logic o_sys_reset, // Reset requested over clock pin
    output logic o_link_busy, // Pins borrowed by a frame
    output logic o_user_data // Data pin level for the application
);

    logic [2:0] ck_sync_q;
    logic [1:0] dt_sync_q;
    logic rise;
    logic fall;
    logic data_s;
    logic [8:0] low_cnt_q;
    logic rst_hit;
    flash_link_pkg::dev_state_t state_q;
    logic [2:0] cnt_q;
    logic [1:0] op_q;
    logic [7:0] sh_q;
    logic [7:0] addr_q;
    logic [7:0] ctrl_q;
    logic [7:0] data_q;
    flash_link_pkg::unlock_t unl_q;
    logic wr_fire;
    logic [7:0] wr_val;
    logic [7:0] rd_val;
    logic out_q;
    logic oe_q;
    logic sys_rst_q;
    logic cmd_valid_q;
    logic [7:0] cmd_code_q;
    logic data_wr_q;
    logic user_q;
    logic en_q;
    logic busy_q;

    // Pin synchronisers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ck_sync_q <= 3'h7;
            dt_sync_q <= 2'h3;
        end else begin
            ck_sync_q <= {ck_sync_q[1:0], lnk.clk_level};
            dt_sync_q <= {dt_sync_q[0], lnk.data_level};
        end
    end

    assign rise = ck_sync_q[1] & ~ck_sync_q[2];
    assign fall = ~ck_sync_q[1] & ck_sync_q[2];
    assign data_s = dt_sync_q[1];

    // Long low on the clock pin is a reset request
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            low_cnt_q <= 9'h000;
        end else if (ck_sync_q[1]) begin
            low_cnt_q <= 9'h000;
        end else if (low_cnt_q != 9'(`LINK_RST_DET_CYC)) begin
            low_cnt_q <= low_cnt_q + 9'h001;
        end
    end

    assign rst_hit = ~ck_sync_q[1] &&
                     (low_cnt_q == 9'(`LINK_RST_DET_CYC - 1)); // R8

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sys_rst_q <= 1'b0;
        end else begin
            sys_rst_q <= rst_hit; // R4
        end
    end

    // Frame sequencer
    assign wr_fire = rise && (state_q == flash_link_pkg::DEV_WDAT) &&
                     (cnt_q == 3'h7);
    assign wr_val = {data_s, sh_q[7:1]};

    always_ff @(posedge i_clk) begin
        if (i_rst || rst_hit) begin
            state_q <= flash_link_pkg::DEV_IDLE;
            cnt_q <= 3'h0;
            op_q <= 2'h0;
        end else if (rise) begin
            case (state_q)
                flash_link_pkg::DEV_IDLE: begin
                    if (!data_s && i_halted) begin // R7
                        state_q <= flash_link_pkg::DEV_OPC;
                        cnt_q <= 3'h0;
                    end
                end
                flash_link_pkg::DEV_OPC: begin
                    op_q <= {op_q[0], data_s};
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == 3'h1) begin
                        cnt_q <= 3'h0;
                        if (data_s) begin
                            state_q <= flash_link_pkg::DEV_WDAT;
                        end else begin
                            state_q <= flash_link_pkg::DEV_TURN;
                        end
                    end
                end
                flash_link_pkg::DEV_WDAT: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == 3'h7) begin
                        state_q <= flash_link_pkg::DEV_IDLE;
                    end
                end
                flash_link_pkg::DEV_TURN: begin
                    state_q <= flash_link_pkg::DEV_RDAT;
                    cnt_q <= 3'h0;
                end
                flash_link_pkg::DEV_RDAT: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == 3'h7) begin
                        state_q <= flash_link_pkg::DEV_IDLE;
                    end
                end
                default: begin
                    state_q <= flash_link_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    // Read source selected by the address register
    always_comb begin
        rd_val = 8'h00;
        if (op_q == `LINK_OP_ADDR_RD) begin
            rd_val = addr_q;
        end else if (addr_q == `ADDR_PROG_CTRL) begin // R1
            rd_val = ctrl_q;
        end else if (addr_q == `ADDR_PROG_DATA) begin // R1
            rd_val = data_q;
        end
    end

    // Shift register: write bits in, read bits out, LSB first
    always_ff @(posedge i_clk) begin
        if (i_rst || rst_hit) begin
            sh_q <= 8'h00;
        end else if (rise && state_q == flash_link_pkg::DEV_WDAT) begin
            sh_q <= wr_val;
        end else if (rise && state_q == flash_link_pkg::DEV_TURN) begin
            sh_q <= rd_val;
        end else if (fall && state_q == flash_link_pkg::DEV_RDAT) begin
            sh_q <= {1'b0, sh_q[7:1]};
        end
    end

    // Data pin drive during the read phase
    always_ff @(posedge i_clk) begin
        if (i_rst || rst_hit) begin
            out_q <= 1'b1;
            oe_q <= 1'b0;
        end else if (fall && state_q == flash_link_pkg::DEV_RDAT) begin
            out_q <= sh_q[0];
            oe_q <= 1'b1;
        end else if (rise && state_q == flash_link_pkg::DEV_RDAT &&
                     cnt_q == 3'h7) begin
            out_q <= 1'b1;
            oe_q <= 1'b0;
        end
    end

    // Address register
    always_ff @(posedge i_clk) begin
        if (i_rst || rst_hit) begin
            addr_q <= `LINK_ADDR_RST;
        end else if (wr_fire && op_q == `LINK_OP_ADDR_WR) begin
            addr_q <= wr_val; // R1
        end
    end

    // Control register and unlock sequence
    always_ff @(posedge i_clk) begin
        if (i_rst || rst_hit) begin
            ctrl_q <= `PROG_CTRL_RST; // R2
            unl_q <= flash_link_pkg::UNL_LOCKED;
        end else if (wr_fire && op_q == `LINK_OP_DATA_WR &&
                     addr_q == `ADDR_PROG_CTRL) begin
            ctrl_q <= wr_val; // R2
            case (unl_q)
                flash_link_pkg::UNL_ENABLED: begin
                    unl_q <= flash_link_pkg::UNL_ENABLED; // R4
                end
                flash_link_pkg::UNL_KEY1_SEEN: begin
                    if (wr_val == `UNLOCK_KEY2) begin
                        unl_q <= flash_link_pkg::UNL_ENABLED; // R3
                    end else if (wr_val != `UNLOCK_KEY1) begin
                        unl_q <= flash_link_pkg::UNL_LOCKED; // R3
                    end
                end
                default: begin
                    if (wr_val == `UNLOCK_KEY1) begin
                        unl_q <= flash_link_pkg::UNL_KEY1_SEEN; // R3
                    end
                end
            endcase
        end
    end

    // Data register and flash command decode
    always_ff @(posedge i_clk) begin
        if (i_rst || rst_hit) begin
            data_q <= `PROG_DATA_RST; // R5
            data_wr_q <= 1'b0;
            cmd_valid_q <= 1'b0;
            cmd_code_q <= 8'h00;
            en_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            data_wr_q <= 1'b0;
            cmd_valid_q <= 1'b0;
            en_q <= (unl_q == flash_link_pkg::UNL_ENABLED); // R3
            busy_q <= (state_q != flash_link_pkg::DEV_IDLE); // R8
            if (wr_fire && op_q == `LINK_OP_DATA_WR &&
                addr_q == `ADDR_PROG_DATA) begin
                data_q <= wr_val; // R5
                data_wr_q <= 1'b1;
                if (unl_q == flash_link_pkg::UNL_ENABLED &&
                    (wr_val == `CMD_BLOCK_RD || wr_val == `CMD_BLOCK_WR ||
                     wr_val == `CMD_PAGE_ERASE ||
                     wr_val == `CMD_DEV_ERASE)) begin
                    cmd_valid_q <= 1'b1; // R6
                    cmd_code_q <= wr_val; // R6
                end
            end
        end
    end

    // Pin sharing toward the application
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            user_q <= 1'b1;
        end else if (!i_halted) begin
            user_q <= data_s; // R9
        end
    end

    assign lnk.data_dev_out = out_q;
    assign lnk.data_dev_oe = oe_q; // R8
    assign o_prog_enabled = en_q;
    assign o_cmd_valid = cmd_valid_q;
    assign o_cmd_code = cmd_code_q;
    assign o_data_wr = data_wr_q;
    assign o_data_byte = data_q;
    assign o_sys_reset = sys_rst_q;
    assign o_link_busy = busy_q; // R8
    assign o_user_data = user_q;

endmodule // flash_link_dev

/* File: inc/flash_link_defines.svh */
// Constants for the two-wire debug link and its flash programming registers.
// Assumes a 20 MHz system clock on both ends.
`ifndef FLASH_LINK_DEFINES_SVH
`define FLASH_LINK_DEFINES_SVH

// Link frame operation codes, two bits, sent MSB first
`define LINK_OP_DATA_RD 2'h0
`define LINK_OP_DATA_WR 2'h1
`define LINK_OP_ADDR_RD 2'h2
`define LINK_OP_ADDR_WR 2'h3

// Device register addresses on the link
`define ADDR_PROG_CTRL 8'h02
`define ADDR_PROG_DATA 8'hB4

// Reset values
`define LINK_ADDR_RST 8'h00
`define PROG_CTRL_RST 8'h00
`define PROG_DATA_RST 8'h00

// Unlock keys, written in this order
`define UNLOCK_KEY1 8'h02
`define UNLOCK_KEY2 8'h01

// Flash command codes
`define CMD_BLOCK_RD 8'h06
`define CMD_BLOCK_WR 8'h07
`define CMD_PAGE_ERASE 8'h08
`define CMD_DEV_ERASE 8'h03

// Timing
`define CLK_PERIOD_NS 50
`define LINK_RST_DET_NS 10000
`define LINK_RST_DET_CYC \
    ((`LINK_RST_DET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LINK_RST_PULSE_NS 20000
`define LINK_RST_PULSE_CYC \
    ((`LINK_RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LINK_HALF_CYC 10

// Host controller registers
`define HREG_CMD 8'h00
`define HREG_WDATA 8'h01
`define HREG_RDATA 8'h02
`define HREG_STATUS 8'h03
`define HCMD_OP_LSB 0
`define HCMD_RST_BIT 7
`define HSTAT_BUSY_BIT 0
`define HSTAT_HALT_BIT 1

`endif

/* File: inc/flash_link_pkg.sv */
// Types shared by both ends of the debug link.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_link_pkg;

    typedef enum logic [2:0] {
        DEV_IDLE, DEV_OPC, DEV_WDAT, DEV_TURN, DEV_RDAT
    } dev_state_t;

    typedef enum logic [1:0] {
        UNL_LOCKED, UNL_KEY1_SEEN, UNL_ENABLED
    } unlock_t;

    typedef enum logic [1:0] {
        HST_IDLE, HST_FRAME, HST_RESET
    } host_state_t;

endpackage

/* File: inc/flash_link_if.sv */
// Two-wire debug link between host adapter and device.
// Data wire is pulled high when neither end drives it.
`timescale 1ns/1ns
interface flash_link_if;
    logic clk_host;
    logic data_host_out;
    logic data_host_oe;
    logic data_dev_out;
    logic data_dev_oe;
    logic clk_level;
    logic data_level;

    assign clk_level = clk_host;
    assign data_level = data_host_oe ? data_host_out :
                        data_dev_oe ? data_dev_out : 1'b1;

    modport dev (
        input clk_level,
        input data_level,
        output data_dev_out,
        output data_dev_oe
    );

    modport host (
        output clk_host,
        output data_host_out,
        output data_host_oe,
        input data_level
    );
endinterface

/* File: verilog/flash_link_host.sv */
// Host adapter end of the two-wire debug link.
// Assumes software drives the plain register port on i_clk.
`timescale 1ns/1ns
`include "flash_link_defines.svh"

module flash_link_host (
    input wire logic i_clk, // System clock
    input wire logic i_rst, // Synchronous reset, high
    input wire logic [7:0] i_addr, // Register address
    input wire logic [7:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [7:0] o_rdata, // Read data, cycle after strobe
    input wire logic i_halted, // Target reported halted
    flash_link_if.host lnk // Link pins
);

    logic [1:0] halt_sync_q;
    flash_link_pkg::host_state_t state_q;
    logic [1:0] op_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_q;
    logic [4:0] div_q;
    logic [3:0] bit_q;
    logic [8:0] rst_cnt_q;
    logic ck_q;
    logic dout_q;
    logic doe_q;
    logic [1:0] din_sync_q;
    logic is_read;
    logic edge_hit;
    logic start_cmd;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            halt_sync_q <= 2'h0;
            din_sync_q <= 2'h3;
        end else begin
            halt_sync_q <= {halt_sync_q[0], i_halted};
            din_sync_q <= {din_sync_q[0], lnk.data_level};
        end
    end

    assign is_read = ~op_q[0];
    assign edge_hit = (div_q == 5'(`LINK_HALF_CYC - 1));
    assign start_cmd = i_wr && i_addr == `HREG_CMD &&
                       state_q == flash_link_pkg::HST_IDLE;

    // Write data register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wdata_q <= 8'h00;
        end else if (i_wr && i_addr == `HREG_WDATA) begin
            wdata_q <= i_wdata;
        end
    end

    // Frame and reset sequencer
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= flash_link_pkg::HST_IDLE;
            op_q <= 2'h0;
            div_q <= 5'h00;
            bit_q <= 4'h0;
            rst_cnt_q <= 9'h000;
            ck_q <= 1'b1;
            dout_q <= 1'b1;
            doe_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            case (state_q)
                flash_link_pkg::HST_IDLE: begin
                    if (start_cmd && i_wdata[`HCMD_RST_BIT]) begin
                        state_q <= flash_link_pkg::HST_RESET; // R4
                        rst_cnt_q <= 9'h000;
                        ck_q <= 1'b0;
                    end else if (start_cmd && halt_sync_q[1]) begin // R7
                        state_q <= flash_link_pkg::HST_FRAME;
                        op_q <= i_wdata[`HCMD_OP_LSB +: 2]; // R1
                        div_q <= 5'h00;
                        bit_q <= 4'h0;
                        ck_q <= 1'b0;
                        dout_q <= 1'b0;
                        doe_q <= 1'b1;
                    end
                end
                flash_link_pkg::HST_RESET: begin
                    rst_cnt_q <= rst_cnt_q + 9'h001;
                    if (rst_cnt_q == 9'(`LINK_RST_PULSE_CYC - 1)) begin
                        ck_q <= 1'b1; // R4
                        state_q <= flash_link_pkg::HST_IDLE;
                    end
                end
                flash_link_pkg::HST_FRAME: begin
                    div_q <= edge_hit ? 5'h00 : div_q + 5'h01;
                    if (edge_hit && !ck_q) begin
                        ck_q <= 1'b1;
                        if (is_read && bit_q >= 4'h4) begin
                            rdata_q <= {din_sync_q[1], rdata_q[7:1]};
                        end
                        if (is_read && bit_q == 4'hB) begin
                            state_q <= flash_link_pkg::HST_IDLE;
                        end
                    end else if (edge_hit && !is_read && bit_q == 4'hA) begin
                        // Last bit held a half period past its rise
                        state_q <= flash_link_pkg::HST_IDLE;
                        doe_q <= 1'b0;
                        dout_q <= 1'b1;
                    end else if (edge_hit && ck_q) begin
                        ck_q <= 1'b0;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h0) begin
                            dout_q <= op_q[1];
                        end else if (bit_q == 4'h1) begin
                            dout_q <= op_q[0];
                        end else if (is_read) begin
                            doe_q <= 1'b0;
                            dout_q <= 1'b1;
                        end else begin
                            dout_q <= wdata_q[bit_q[2:0] - 3'h2]; // R3 R6
                        end
                    end
                end
                default: begin
                    state_q <= flash_link_pkg::HST_IDLE;
                end
            endcase
        end
    end

    // Register read port
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_q <= 8'h00;
        end else if (i_rd) begin
            if (i_addr == `HREG_CMD) begin
                rd_q <= {6'h00, op_q};
            end else if (i_addr == `HREG_WDATA) begin
                rd_q <= wdata_q;
            end else if (i_addr == `HREG_RDATA) begin
                rd_q <= rdata_q;
            end else if (i_addr == `HREG_STATUS) begin
                rd_q <= {6'h00, halt_sync_q[1],
                         state_q != flash_link_pkg::HST_IDLE};
            end else begin
                rd_q <= 8'h00;
            end
        end else begin
            rd_q <= 8'h00;
        end
    end

    assign o_rdata = rd_q;
    assign lnk.clk_host = ck_q;
    assign lnk.data_host_out = dout_q;
    assign lnk.data_host_oe = doe_q;

endmodule // flash_link_host

/* File: testbench/flash_link_checker.sv */
// Wire-level checks on the link joining host and device ends.
// Assumes both ends run on i_clk with synchronous reset i_rst.
`timescale 1ns/1ns
module flash_link_checker (
    input wire logic i_clk, // System clock
    input wire logic i_rst, // Synchronous reset, high
    input wire logic clk_host, // Link clock from host
    input wire logic data_host_out, // Host data drive
    input wire logic data_host_oe, // Host drive enable
    input wire logic data_dev_out, // Device data drive
    input wire logic data_dev_oe, // Device drive enable
    input wire logic clk_level, // Clock wire level
    input wire logic data_level // Data wire level
);
    logic [9:0] low_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Cycles the link clock has stayed low
    always_ff @(posedge i_clk) begin
        if (i_rst || clk_host) begin
            low_q <= '0;
        end else begin
            low_q <= low_q + 10'h001;
        end
    end
    rst_idle_a: assert property ($fell(i_rst) |->
        clk_host && !data_host_oe && !data_dev_oe)
        else $error("link not idle after reset");
    no_clash_a: assert property (!(data_host_oe && data_dev_oe))
        else $error("both ends drive data");
    low_time_a: assert property ($rose(clk_host) |->
        low_q == 10'h00A || low_q == 10'h190)
        else $error("link clock low time wrong");
    start_bit_a: assert property ($rose(data_host_oe) |->
        !data_host_out && !clk_host)
        else $error("frame start malformed");
    host_setup_a: assert property (data_host_oe && $past(data_host_oe)
        && $changed(data_host_out) |-> !clk_host)
        else $error("host data moved with clock high");
    dev_hold_a: assert property (data_dev_oe && clk_host
        && $past(clk_host) |-> $stable(data_dev_out))
        else $error("device data moved with clock high");
    dev_turn_a: assert property ($rose(data_dev_oe) |->
        !data_host_oe && !$past(data_host_oe))
        else $error("device drove before turnaround");
    host_frame_a: assert property ($rose(data_host_oe) |->
        ##[1:240] !data_host_oe)
        else $error("host held data too long");
    dev_release_a: assert property ($rose(data_dev_oe) |->
        ##[100:200] !data_dev_oe)
        else $error("device read phase length wrong");
    pull_up_a: assert property (!data_host_oe && !data_dev_oe |->
        data_level && clk_level == clk_host)
        else $error("idle data wire not pulled high");
    cover property ($rose(data_dev_oe));
    cover property ($rose(clk_host) && low_q == 10'h190);
    cover property ($fell(data_host_oe) && !data_dev_oe);
endmodule // flash_link_checker

/* File: testbench/two_wire_flash_prog_regs_test.sv */
// Bench: software port drives host, model checks device registers.
// Assumes the link interface and both design ends compile first.
`timescale 1ns/1ns
`include "flash_link_defines.svh"
module two_wire_flash_prog_regs_test;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_halted = 1'b1;
    logic [7:0] o_rdata, o_cmd_code, o_data_byte, q;
    logic o_prog_enabled, o_cmd_valid, o_data_wr, o_sys_reset;
    logic o_link_busy, o_user_data;
    logic [31:0] rnd = 32'h0E379DB3;
    logic [7:0] codes [4] = '{`CMD_BLOCK_RD, `CMD_BLOCK_WR,
        `CMD_PAGE_ERASE, `CMD_DEV_ERASE};
    logic [7:0] keys [6] = '{8'h01, 8'h02, 8'h05, 8'h02, 8'h02, 8'h01};
    int failures = 0, comparisons = 0;
    int m_addr = 0, m_ctrl = 0, m_data = 0, m_unl = 0, m_cmds = 0;
    int m_dwr = 0, cmd_seen = 0, dwr_seen = 0, rst_seen = 0;
    flash_link_if lnk_bus();
    flash_link_host flash_link_host_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_halted(i_halted), .lnk(lnk_bus));
    flash_link_dev flash_link_dev_inst (.i_clk(i_clk), .i_rst(i_rst),
        .lnk(lnk_bus), .i_halted(i_halted),
        .o_prog_enabled(o_prog_enabled), .o_cmd_valid(o_cmd_valid),
        .o_cmd_code(o_cmd_code), .o_data_wr(o_data_wr),
        .o_data_byte(o_data_byte), .o_sys_reset(o_sys_reset),
        .o_link_busy(o_link_busy), .o_user_data(o_user_data));
    flash_link_checker flash_link_checker_inst (.i_clk(i_clk),
        .i_rst(i_rst), .clk_host(lnk_bus.clk_host),
        .data_host_out(lnk_bus.data_host_out),
        .data_host_oe(lnk_bus.data_host_oe),
        .data_dev_out(lnk_bus.data_dev_out),
        .data_dev_oe(lnk_bus.data_dev_oe),
        .clk_level(lnk_bus.clk_level), .data_level(lnk_bus.data_level));
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cmd_seen <= cmd_seen + (o_cmd_valid === 1'b1);
        dwr_seen <= dwr_seen + (o_data_wr === 1'b1);
        rst_seen <= rst_seen + (o_sys_reset === 1'b1);
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_count(input int g, input int e);
        comparisons++;
        if (g != e) begin
            failures++;
            $display("ERROR %0t count %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic frame(input logic [1:0] op, input logic [7:0] d);
        logic [7:0] s;
        int n;
        wr(`HREG_WDATA, d);
        wr(`HREG_CMD, {6'h00, op});
        s = 8'h01;
        n = 0;
        while (s[`HSTAT_BUSY_BIT] !== 1'b0 && n < 500) begin
            rd(`HREG_STATUS, s);
            chk_byte({7'h00, o_user_data}, 8'h01);
            n++;
        end
        chk_count(n < 500, 1);
        repeat (6) @(posedge i_clk);
        rd(`HREG_RDATA, q);
    endtask
    task automatic state();
        chk_byte(o_data_byte, m_data[7:0]);
        chk_byte({7'h00, o_prog_enabled}, m_unl == 2);
        chk_count(cmd_seen, m_cmds);
        chk_count(dwr_seen, m_dwr);
        chk_byte({7'h00, o_user_data}, 8'h01);
        chk_byte({7'h00, o_link_busy}, 8'h00);
    endtask
    task automatic dwr(input logic [7:0] d);
        frame(`LINK_OP_DATA_WR, d);
        if (m_addr == `ADDR_PROG_CTRL) begin
            m_ctrl = d;
            if (m_unl != 2) begin
                m_unl = d == `UNLOCK_KEY1 ? 1 :
                    (m_unl == 1 && d == `UNLOCK_KEY2) ? 2 : 0;
            end
        end else if (m_addr == `ADDR_PROG_DATA) begin
            m_data = d;
            m_dwr++;
            if (m_unl == 2 && d inside {codes}) begin
                m_cmds++;
                chk_byte(o_cmd_code, d);
            end
        end
        state();
    endtask
    task automatic dread();
        frame(`LINK_OP_DATA_RD, 8'h00);
        chk_byte(q, m_addr == `ADDR_PROG_CTRL ? m_ctrl[7:0] :
            m_addr == `ADDR_PROG_DATA ? m_data[7:0] : 8'h00);
    endtask
    task automatic awr(input logic [7:0] a);
        frame(`LINK_OP_ADDR_WR, a);
        m_addr = a;
        frame(`LINK_OP_ADDR_RD, 8'h00);
        chk_byte(q, a);
    endtask
    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        failures++;
        results();
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        for (int p = 0; p < 2; p++) begin
            frame(`LINK_OP_ADDR_RD, 8'h00);
            chk_byte(q, 8'h00);
            awr(`ADDR_PROG_CTRL);
            dread();
            awr(`ADDR_PROG_DATA);
            dread();
            dwr(`CMD_BLOCK_RD);
            if (p == 1) begin
                break;
            end
            awr(`ADDR_PROG_CTRL);
            foreach (keys[i]) begin
                dwr(keys[i]);
            end
            dread();
            dwr(8'h55);
            awr(`ADDR_PROG_DATA);
            foreach (codes[i]) begin
                dwr(codes[i]);
            end
            repeat (4) begin
                rnd = lfsr(rnd);
                dwr(rnd[7:0]);
                dread();
            end
            awr(8'h33);
            dwr(8'hAA);
            dread();
            rd(8'h05, q);
            chk_byte(q, 8'h00);
            awr(`ADDR_PROG_DATA);
            i_halted <= 1'b0;
            frame(`LINK_OP_DATA_WR, 8'h11);
            state();
            i_halted <= 1'b1;
            wr(`HREG_CMD, 8'h80);
            repeat (450) @(posedge i_clk);
            m_addr = 0;
            m_ctrl = 0;
            m_data = 0;
            m_unl = 0;
            chk_count(rst_seen, 1);
            state();
        end
        results();
    end
endmodule // two_wire_flash_prog_regs_test
